// ===== dv/ldf_fault_check_tb.sv
// Self-checking bench for the legacy remap fault checker.
// Assumes the checker, its package and ldf_params.svh are compiled first.
`timescale 1ns/1ps
`include "ldf_params.svh"

module ldf_fault_check_tb;

	localparam ldf_pkg::ldf_kind_t k_u = ldf_pkg::LDF_UNTRANSLATED;
	localparam ldf_pkg::ldf_kind_t k_x = ldf_pkg::LDF_TRANSLATION;
	localparam ldf_pkg::ldf_kind_t k_t = ldf_pkg::LDF_TRANSLATED;
	localparam ldf_pkg::ldf_kind_t k_pr = ldf_pkg::LDF_PAGE_RESP;
	localparam ldf_pkg::ldf_kind_t k_pn = ldf_pkg::LDF_PAGE_NORESP;
	localparam ldf_pkg::ldf_status_t s_ok = ldf_pkg::LDF_SUCCESS;
	localparam ldf_pkg::ldf_status_t s_ur = ldf_pkg::LDF_UR;
	localparam ldf_pkg::ldf_status_t s_ca = ldf_pkg::LDF_CA;
	localparam ldf_pkg::ldf_status_t s_ir = ldf_pkg::LDF_IR;
	localparam ldf_pkg::ldf_status_t s_dr = ldf_pkg::LDF_DROP;
	localparam logic [63:0] a_lo = 64'h0000000000100000;
	localparam logic [63:0] a_m39 = 64'h0000007FFFFFFFFF;
	localparam logic [63:0] a_b39 = 64'h0000008000000000;
	localparam logic [63:0] a_b40 = 64'h0000010000000000;
	localparam logic [63:0] a_m46 = 64'h00003FFFFFFFFFFF;
	localparam logic [63:0] a_b46 = 64'h0000400000000000;
	localparam logic [63:0] a_b48 = 64'h0001000000000000;
	localparam logic [63:0] a_win = 64'h00000000FEE01000;
	localparam logic [6:0] w39 = 7'h27;
	localparam logic [6:0] w64 = 7'h40;
	localparam logic [1:0] t0 = 2'h0;
	localparam logic [1:0] tp = 2'h2;

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_valid;
	ldf_pkg::ldf_kind_t req_kind;
	logic [8:0] flags;
	logic [63:0] req_addr;
	logic [63:0] out_addr;
	logic [6:0] ctx_width;
	logic [1:0] xlate_type;
	logic rsp_valid;
	ldf_pkg::ldf_status_t rsp_status;
	logic perm_rd;
	logic perm_wr;
	logic fault_valid;
	logic [7:0] fault_reason;
	logic fault_qual;
	logic irq;
	logic [31:0] rdata;
	logic rerr;
	int mismatches = 0;
	int check_count = 0;

	always #50 ref_clk = ~ref_clk;

	ldf_root_port_model ldf_root_port_model_i (
		.clk(ref_clk), .req_valid(req_valid), .req_kind(req_kind),
		.req_flags(flags), .req_addr(req_addr), .out_addr(out_addr),
		.ctx_width(ctx_width), .xlate_type(xlate_type)
	);

	ldf_fault_check ldf_fault_check_i (
		.REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
		.REQ_HAS_PASID(flags[7]), .REQ_IS_READ(flags[6]),
		.REQ_IS_WRITE(flags[5]), .REQ_IS_ATOMIC(flags[4]),
		.REQ_ZERO_LEN(flags[3]), .REQ_ADDR(req_addr),
		.OUT_ADDR(out_addr), .CTX_ADDR_WIDTH(ctx_width),
		.CTX_XLATE_TYPE(xlate_type), .ENTRY_RSVD_NZ(flags[2]),
		.ENTRY_READ(flags[1]), .ENTRY_WRITE(flags[0]),
		.ROOT_PTR_BAD(flags[8]), .RSP_VALID(rsp_valid),
		.RSP_STATUS(rsp_status), .RSP_PERM_READ(perm_rd),
		.RSP_PERM_WRITE(perm_wr), .FAULT_VALID(fault_valid),
		.FAULT_REASON(fault_reason), .FAULT_QUALIFIED(fault_qual),
		.IRQ(irq)
	);

	// ------------------------------------------------------------------
	// Compare, bus and request tasks
	// ------------------------------------------------------------------
	task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : cmp

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task reg_wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		#1;
	endtask : reg_wr

	task reg_rd(input logic [11:0] a, input logic [31:0] e,
		input logic ee);
		apb(1'b0, a, 32'h0);
		cmp("prdata", {32'h0, e}, {32'h0, rdata});
		cmp("pslverr", {63'h0, ee}, {63'h0, rerr});
	endtask : reg_rd

	// Flags: bad root, pasid, rd, wr, atomic, zero len, rsvd, R, W
	// x is qualified flag on a fault, returned perms on success
	task req(input ldf_pkg::ldf_kind_t k, input logic [8:0] f,
		input logic [63:0] a, input logic [63:0] o, input logic [6:0] w,
		input logic [1:0] t, input ldf_pkg::ldf_status_t es,
		input logic [7:0] er, input logic [1:0] x);
		ldf_root_port_model_i.send(k, f, a, o, w, t);
		#1;
		cmp("rsp_valid", 64'h1, {63'h0, rsp_valid});
		cmp("rsp_status", {61'h0, es}, {61'h0, rsp_status});
		cmp("fault_valid", {63'h0, er != 8'h00}, {63'h0, fault_valid});
		if (er != 8'h00) begin
			cmp("fault_reason", {56'h0, er}, {56'h0, fault_reason});
			cmp("fault_qual", {63'h0, x[0]}, {63'h0, fault_qual});
		end
		if (es == s_ok)
			cmp("perms", {62'h0, x}, {62'h0, perm_rd, perm_wr});
		@(posedge ref_clk);
		#1;
		cmp("rsp_pulse", 64'h0, {63'h0, rsp_valid});
	endtask : req

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		report_and_stop();
	end

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		reg_rd(`LDF_OFF_ROOT, 32'h0, 1'b0);
		reg_rd(`LDF_OFF_CAP, 32'h00002E30, 1'b0);
		reg_rd(`LDF_OFF_STAT, 32'h0, 1'b0);
		reg_rd(`LDF_OFF_MASK, 32'h0, 1'b0);
		reg_rd(12'h014, 32'h0, 1'b1);
		req(k_u, 9'h047, a_lo, a_lo, w39, t0, s_ur, 8'h0C, 2'h1);
		req(k_x, 9'h047, a_lo, a_lo, w39, t0, s_ca, 8'h0C, 2'h1);
		req(k_u, 9'h044, a_lo, a_lo, w39, t0, s_ur, 8'h06, 2'h1);
		req(k_u, 9'h043, a_b39, a_lo, w39, t0, s_ur, 8'h04, 2'h1);
		req(k_u, 9'h043, a_m39, a_lo, w39, t0, s_ok, 8'h00, 2'h3);
		req(k_x, 9'h043, a_b39, a_lo, w39, t0, s_ok, 8'h00, 2'h0);
		req(k_u, 9'h043, a_b39, a_lo, w64, t0, s_ok, 8'h00, 2'h3);
		req(k_u, 9'h043, a_b48, a_lo, w64, t0, s_ur, 8'h04, 2'h1);
		req(k_t, 9'h043, a_b46, a_b46, w39, t0, s_ur, 8'h04, 2'h1);
		req(k_t, 9'h043, a_m46, a_m46, w39, t0, s_ok, 8'h00, 2'h3);
		req(k_u, 9'h043, a_b46, a_b46, w39, tp, s_ur, 8'h04, 2'h1);
		req(k_u, 9'h040, a_b40, a_b40, w39, tp, s_ok, 8'h00, 2'h3);
		req(k_x, 9'h043, a_b46, a_b46, w39, tp, s_ok, 8'h00, 2'h0);
		req(k_u, 9'h022, a_lo, a_lo, w39, t0, s_ur, 8'h05, 2'h1);
		req(k_u, 9'h012, a_lo, a_lo, w39, t0, s_ur, 8'h05, 2'h1);
		req(k_x, 9'h022, a_lo, a_lo, w39, t0, s_ok, 8'h00, 2'h2);
		req(k_u, 9'h041, a_lo, a_lo, w39, t0, s_ur, 8'h06, 2'h1);
		req(k_u, 9'h011, a_lo, a_lo, w39, t0, s_ur, 8'h06, 2'h1);
		req(k_x, 9'h041, a_lo, a_lo, w39, t0, s_ok, 8'h00, 2'h1);
		req(k_u, 9'h049, a_lo, a_lo, w39, t0, s_ur, 8'h06, 2'h1);
		req(k_u, 9'h043, a_lo, a_win, w39, t0, s_ur, 8'h0E, 2'h1);
		req(k_x, 9'h043, a_lo, a_win, w39, t0, s_ca, 8'h0E, 2'h1);
		req(k_t, 9'h043, a_win, a_lo, w39, t0, s_ur, 8'h0E, 2'h1);
		req(k_u, 9'h043, a_win, a_lo, w39, tp, s_ur, 8'h0E, 2'h1);
		req(k_u, 9'h043, a_win, a_lo, w39, t0, s_ok, 8'h00, 2'h3);
		req(k_u, 9'h143, a_lo, a_lo, w39, t0, s_ur, 8'h30, 2'h0);
		req(k_x, 9'h0C3, a_lo, a_lo, w39, t0, s_ur, 8'h31, 2'h0);
		req(k_u, 9'h0C3, a_lo, a_lo, w39, t0, s_ur, 8'h31, 2'h0);
		reg_rd(`LDF_OFF_LAST, 32'h00000231, 1'b0);
		// Interrupt: both status bits set, masked, then cleared
		reg_rd(`LDF_OFF_STAT, 32'h3, 1'b0);
		cmp("irq", 64'h0, {63'h0, irq});
		reg_wr(`LDF_OFF_MASK, 32'h1);
		cmp("irq", 64'h1, {63'h0, irq});
		reg_wr(`LDF_OFF_STAT, 32'h1);
		cmp("irq", 64'h0, {63'h0, irq});
		reg_rd(`LDF_OFF_STAT, 32'h2, 1'b0);
		reg_wr(`LDF_OFF_MASK, 32'h3);
		cmp("irq", 64'h1, {63'h0, irq});
		reg_wr(`LDF_OFF_STAT, 32'h2);
		cmp("irq", 64'h0, {63'h0, irq});
		reg_rd(`LDF_OFF_STAT, 32'h0, 1'b0);
		reg_wr(`LDF_OFF_CAP, 32'h00012E30);
		reg_rd(`LDF_OFF_CAP, 32'h00012E30, 1'b0);
		req(k_u, 9'h049, a_lo, a_lo, w39, t0, s_ok, 8'h00, 2'h1);
		req(k_u, 9'h041, a_lo, a_lo, w39, t0, s_ur, 8'h06, 2'h1);
		req(k_pr, 9'h043, a_lo, a_lo, w39, t0, s_ir, 8'h32, 2'h0);
		req(k_pn, 9'h043, a_lo, a_lo, w39, t0, s_dr, 8'h32, 2'h0);
		// Clock enable low: request ignored, results hold
		@(posedge ref_clk);
		clk_en <= 1'b0;
		ldf_root_port_model_i.send(k_u, 9'h041, a_lo, a_lo, w39, t0);
		#1;
		cmp("frozen rsp_valid", 64'h0, {63'h0, rsp_valid});
		cmp("frozen fault_reason", 64'h32, {56'h0, fault_reason});
		@(posedge ref_clk);
		clk_en <= 1'b1;
		// Both unsupported table modes behave alike
		for (int m = 2; m < 4; m++) begin
			reg_wr(`LDF_OFF_ROOT, 32'(m));
			req(k_u, 9'h047, a_lo, a_lo, w39, t0, s_ur, 8'h30, 2'h0);
			req(k_x, 9'h047, a_lo, a_lo, w39, t0, s_ca, 8'h30, 2'h0);
			req(k_t, 9'h047, a_lo, a_lo, w39, t0, s_ur, 8'h30, 2'h0);
			req(k_pr, 9'h047, a_lo, a_lo, w39, t0, s_ir, 8'h30, 2'h0);
			req(k_pn, 9'h047, a_lo, a_lo, w39, t0, s_dr, 8'h30, 2'h0);
		end
		reg_wr(`LDF_OFF_ROOT, 32'h1);
		req(k_u, 9'h047, a_b48, a_win, w39, t0, s_ok, 8'h00, 2'h3);
		report_and_stop();
	end

endmodule : ldf_fault_check_tb

// ===== dv/ldf_root_port_model.sv
// Root port model: forwards one device request per call to the checker.
// Assumes the checker samples requests at the rising edge of clk.
`timescale 1ns/1ps

module ldf_root_port_model (
	input wire logic clk,
	output logic req_valid,
	output ldf_pkg::ldf_kind_t req_kind,
	output logic [8:0] req_flags,
	output logic [63:0] req_addr,
	output logic [63:0] out_addr,
	output logic [6:0] ctx_width,
	output logic [1:0] xlate_type
);

	initial begin
		req_valid = 1'b0;
		req_kind = ldf_pkg::LDF_UNTRANSLATED;
		req_flags = 9'h000;
		req_addr = 64'h0;
		out_addr = 64'h0;
		ctx_width = 7'h27;
		xlate_type = 2'h0;
	end

	// ------------------------------------------------------------------
	// Request issue
	// ------------------------------------------------------------------
	task send(input ldf_pkg::ldf_kind_t k, input logic [8:0] f,
		input logic [63:0] a, input logic [63:0] o,
		input logic [6:0] w, input logic [1:0] t);
		@(posedge clk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_flags <= f;
		req_addr <= a;
		out_addr <= o;
		ctx_width <= w;
		xlate_type <= t;
		@(posedge clk);
		// Released lines except req_kind inverted so stale values cannot pass
		req_valid <= 1'b0;
		req_flags <= ~f;
		req_addr <= ~a;
		out_addr <= ~o;
		ctx_width <= ~w;
		xlate_type <= ~t;
	endtask : send

endmodule : ldf_root_port_model

// ===== rtl/ldf_fault_check.sv
// Legacy-mode fault checker of a DMA remapping unit, with APB registers.
// Assumes walker results are valid with REQ_VALID, same clock domain.
`timescale 1ns/1ps
`include "ldf_params.svh"

module ldf_fault_check (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`LDF_AW-1:0] PADDR,
	input wire logic [`LDF_DW-1:0] PWDATA,
	output logic [`LDF_DW-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic REQ_VALID,
	input ldf_pkg::ldf_kind_t REQ_KIND,
	input wire logic REQ_HAS_PASID,
	input wire logic REQ_IS_READ,
	input wire logic REQ_IS_WRITE,
	input wire logic REQ_IS_ATOMIC,
	input wire logic REQ_ZERO_LEN,
	input wire logic [63:0] REQ_ADDR,
	input wire logic [63:0] OUT_ADDR,
	input wire logic [`LDF_WW-1:0] CTX_ADDR_WIDTH,
	input wire logic [1:0] CTX_XLATE_TYPE,
	input wire logic ENTRY_RSVD_NZ,
	input wire logic ENTRY_READ,
	input wire logic ENTRY_WRITE,
	input wire logic ROOT_PTR_BAD,
	output logic RSP_VALID,
	output ldf_pkg::ldf_status_t RSP_STATUS,
	output logic RSP_PERM_READ,
	output logic RSP_PERM_WRITE,
	output logic FAULT_VALID,
	output logic [7:0] FAULT_REASON,
	output logic FAULT_QUALIFIED,
	output logic IRQ
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [1:0] table_mode_field;
	logic [`LDF_WW-1:0] max_guest_addr_width;
	logic [`LDF_WW-1:0] host_addr_width;
	logic zero_length_read_cap;
	logic [`LDF_ST_W-1:0] status;
	logic [`LDF_ST_W-1:0] mask;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	wire sel_root = PADDR == `LDF_OFF_ROOT;
	wire sel_cap = PADDR == `LDF_OFF_CAP;
	wire sel_stat = PADDR == `LDF_OFF_STAT;
	wire sel_mask = PADDR == `LDF_OFF_MASK;
	wire sel_last = PADDR == `LDF_OFF_LAST;
	wire mapped = sel_root | sel_cap | sel_stat | sel_mask | sel_last;
	wire setup = PSEL & ~PENABLE;
	wire access = PSEL & PENABLE;
	wire wr = access & PWRITE & CLK_EN;

	// Zero wait states keep the request path free of any stall
	assign PREADY = 1'b1;
	assign PSLVERR = access & ~mapped;

	wire [`LDF_DW-1:0] rd_root = {{(`LDF_DW-2){1'b0}}, table_mode_field};
	wire [`LDF_DW-1:0] rd_cap = {15'h0000, zero_length_read_cap,
		1'b0, host_addr_width, 1'b0, max_guest_addr_width};
	wire [`LDF_DW-1:0] rd_stat = {{(`LDF_DW-`LDF_ST_W){1'b0}}, status};
	wire [`LDF_DW-1:0] rd_mask = {{(`LDF_DW-`LDF_ST_W){1'b0}}, mask};
	wire [`LDF_DW-1:0] rd_last = {20'h00000, RSP_STATUS, FAULT_QUALIFIED,
		FAULT_REASON};
	wire [`LDF_DW-1:0] next_prdata = sel_root ? rd_root :
		sel_cap ? rd_cap :
		sel_stat ? rd_stat :
		sel_mask ? rd_mask :
		sel_last ? rd_last : 32'h00000000;

	// ------------------------------------------------------------------
	// Mode and request decode
	// ------------------------------------------------------------------
	// legacy mode gate
	wire legacy = table_mode_field == `LDF_MODE_LEGACY;
	wire root_bad = ROOT_PTR_BAD |
		(table_mode_field == `LDF_MODE_RSVD3) |
		(table_mode_field == `LDF_MODE_RSVD2);
	wire is_untr = REQ_KIND == ldf_pkg::LDF_UNTRANSLATED;
	wire is_tr = REQ_KIND == ldf_pkg::LDF_TRANSLATION;
	wire is_trd = REQ_KIND == ldf_pkg::LDF_TRANSLATED;
	wire is_page = (REQ_KIND == ldf_pkg::LDF_PAGE_RESP) |
		(REQ_KIND == ldf_pkg::LDF_PAGE_NORESP);
	wire passthru = CTX_XLATE_TYPE == `LDF_TT_PASS;
	wire dma_req = (is_untr | is_tr) & ~REQ_HAS_PASID;
	// Pass-through and translated requests never touch paging entries
	wire paged = dma_req & ~passthru;

	// ------------------------------------------------------------------
	// Address checks
	// ------------------------------------------------------------------
	wire [`LDF_WW-1:0] guest_width = (max_guest_addr_width < CTX_ADDR_WIDTH)
		? max_guest_addr_width : CTX_ADDR_WIDTH;
	logic over_guest;
	logic over_host;

	ldf_width_check u_guest (
		.addr(REQ_ADDR),
		.width(guest_width),
		.above(over_guest)
	);

	ldf_width_check u_host (
		.addr(REQ_ADDR),
		.width(host_addr_width),
		.above(over_host)
	);

	// request address stands as output address for translated and pass-through requests
	wire [63:0] eff_out = (is_trd | passthru) ? REQ_ADDR : OUT_ADDR;
	wire in_win = eff_out[63:`LDF_WIN_LO] == `LDF_WIN_BASE;

	wire zlr_skip = zero_length_read_cap & REQ_ZERO_LEN & ENTRY_WRITE &
		~ENTRY_READ;
	wire need_read = (REQ_IS_READ | REQ_IS_ATOMIC) & ~zlr_skip;
	wire need_write = REQ_IS_WRITE | REQ_IS_ATOMIC;

	// ------------------------------------------------------------------
	// Fault conditions
	// ------------------------------------------------------------------
	// PASID not allowed in legacy mode
	wire f_pasid = legacy & (is_untr | is_tr) & REQ_HAS_PASID;
	wire f_page = legacy & is_page;
	wire f_rsvd = legacy & paged & ENTRY_RSVD_NZ & (ENTRY_READ | ENTRY_WRITE);
	wire f_aw = legacy & dma_req & (passthru ? over_host : over_guest);
	wire f_haw = legacy & is_trd & over_host;
	wire f_win = legacy & (dma_req | is_trd) & in_win;
	wire f_wr = legacy & paged & is_untr & need_write & ~ENTRY_WRITE;
	wire f_rd = legacy & paged & is_untr & need_read & ~ENTRY_READ;

	// ------------------------------------------------------------------
	// Outcome ladder
	// ------------------------------------------------------------------
	ldf_pkg::ldf_status_t next_status;
	logic [7:0] next_reason;
	logic next_fault;
	logic next_qual;
	logic next_perm_r;
	logic next_perm_w;

	// Fixed priority: mode errors first, then entry, width, window, access
	always_comb begin
		next_status = ldf_pkg::LDF_SUCCESS;
		next_reason = 8'h00;
		next_fault = 1'b0;
		next_qual = 1'b0;
		next_perm_r = passthru | ENTRY_READ;
		next_perm_w = passthru | ENTRY_WRITE;
		if (root_bad) begin
			next_fault = 1'b1;
			next_reason = `LDF_RSN_ROOT;
			unique case (REQ_KIND)
				ldf_pkg::LDF_TRANSLATION: next_status = ldf_pkg::LDF_CA;
				ldf_pkg::LDF_PAGE_RESP: next_status = ldf_pkg::LDF_IR;
				ldf_pkg::LDF_PAGE_NORESP: next_status = ldf_pkg::LDF_DROP;
				ldf_pkg::LDF_UNTRANSLATED,
				ldf_pkg::LDF_TRANSLATED: next_status = ldf_pkg::LDF_UR;
				default: next_status = ldf_pkg::LDF_UR;
			endcase
		end else if (f_pasid) begin
			next_fault = 1'b1;
			next_reason = `LDF_RSN_PASID;
			next_status = ldf_pkg::LDF_UR;
		end else if (f_page) begin
			next_fault = 1'b1;
			next_reason = `LDF_RSN_PAGE;
			next_status = (REQ_KIND == ldf_pkg::LDF_PAGE_RESP) ?
				ldf_pkg::LDF_IR : ldf_pkg::LDF_DROP;
		end else if (f_rsvd) begin
			next_fault = 1'b1;
			next_qual = 1'b1;
			next_reason = `LDF_RSN_RSVD;
			next_status = is_tr ? ldf_pkg::LDF_CA : ldf_pkg::LDF_UR;
		end else if (f_aw | f_haw) begin
			next_perm_r = 1'b0;
			next_perm_w = 1'b0;
			// Translation requests succeed with no permissions, unreported
			if (!is_tr) begin
				next_fault = 1'b1;
				next_qual = 1'b1;
				next_reason = `LDF_RSN_OVER;
				next_status = ldf_pkg::LDF_UR;
			end
		end else if (f_win) begin
			next_fault = 1'b1;
			next_qual = 1'b1;
			next_reason = `LDF_RSN_WIN;
			next_status = is_tr ? ldf_pkg::LDF_CA : ldf_pkg::LDF_UR;
		end else if (f_wr) begin
			next_fault = 1'b1;
			next_qual = 1'b1;
			next_reason = `LDF_RSN_WRITE;
			next_status = ldf_pkg::LDF_UR;
		end else if (f_rd) begin
			next_fault = 1'b1;
			next_qual = 1'b1;
			next_reason = `LDF_RSN_READ;
			next_status = ldf_pkg::LDF_UR;
		end
	end

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	wire take = CLK_EN & REQ_VALID;

	// reason, flag and status in one cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RSP_VALID <= 1'b0;
			FAULT_VALID <= 1'b0;
		end else if (CLK_EN) begin
			RSP_VALID <= REQ_VALID;
			FAULT_VALID <= REQ_VALID & next_fault;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RSP_STATUS <= ldf_pkg::LDF_SUCCESS;
			RSP_PERM_READ <= 1'b0;
			RSP_PERM_WRITE <= 1'b0;
			FAULT_REASON <= 8'h00;
			FAULT_QUALIFIED <= 1'b0;
		end else if (take) begin
			RSP_STATUS <= next_status;
			RSP_PERM_READ <= next_perm_r;
			RSP_PERM_WRITE <= next_perm_w;
			FAULT_REASON <= next_reason;
			FAULT_QUALIFIED <= next_qual;
		end
	end

	// ------------------------------------------------------------------
	// Register writes and interrupt status
	// ------------------------------------------------------------------
	wire [`LDF_ST_W-1:0] st_set = {take & next_fault & ~next_qual,
		take & next_fault & next_qual};
	wire [`LDF_ST_W-1:0] st_clr = (wr & sel_stat) ?
		PWDATA[`LDF_ST_W-1:0] : 2'h0;
	// A fault in the clearing cycle survives the clear
	wire [`LDF_ST_W-1:0] next_status_bits = (status & ~st_clr) | st_set;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			table_mode_field <= `LDF_RST_MODE;
			max_guest_addr_width <= `LDF_RST_MAX_GUEST_ADDR_WIDTH;
			host_addr_width <= `LDF_RST_HAW;
			zero_length_read_cap <= `LDF_RST_ZLR;
			mask <= 2'h0;
		end else if (wr) begin
			if (sel_root) begin
				table_mode_field <= PWDATA[`LDF_MODE_HI:`LDF_MODE_LO];
			end
			if (sel_cap) begin
				max_guest_addr_width <= PWDATA[`LDF_MAX_GUEST_ADDR_WIDTH_HI:`LDF_MAX_GUEST_ADDR_WIDTH_LO];
				host_addr_width <= PWDATA[`LDF_HAW_HI:`LDF_HAW_LO];
				zero_length_read_cap <= PWDATA[`LDF_ZLR_BIT];
			end
			if (sel_mask) begin
				mask <= PWDATA[`LDF_ST_W-1:0];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			status <= 2'h0;
			PRDATA <= 32'h00000000;
		end else if (CLK_EN) begin
			status <= next_status_bits;
			if (setup) begin
				PRDATA <= next_prdata;
			end
		end
	end

	assign IRQ = |(status & mask);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	wire clean_path = ~root_bad & legacy & ~REQ_HAS_PASID & ~passthru;

	a_reserved_entry: assert property (
		take & clean_path & is_untr & ENTRY_RSVD_NZ & ENTRY_READ
		|=> FAULT_VALID && FAULT_REASON == `LDF_RSN_RSVD &&
			FAULT_QUALIFIED && RSP_STATUS == ldf_pkg::LDF_UR)
		else $error("reserved entry fault wrong");

	a_guest_overflow: assert property (
		take & clean_path & is_tr & ~ENTRY_RSVD_NZ & over_guest
		|=> RSP_VALID && RSP_STATUS == ldf_pkg::LDF_SUCCESS &&
			!RSP_PERM_READ && !RSP_PERM_WRITE)
		else $error("translation overflow not zero-permission success");

	a_host_overflow: assert property (
		take & legacy & ~root_bad & is_trd & over_host
		|=> FAULT_REASON == `LDF_RSN_OVER && RSP_STATUS == ldf_pkg::LDF_UR)
		else $error("translated host overflow missed");

	a_write_perm: assert property (
		take & clean_path & is_untr & REQ_IS_WRITE & ~ENTRY_WRITE &
		~f_rsvd & ~f_aw & ~f_win
		|=> FAULT_VALID && FAULT_REASON == `LDF_RSN_WRITE)
		else $error("write permission fault missed");

	a_zero_len: assert property (
		take & clean_path & is_untr & zero_length_read_cap & REQ_ZERO_LEN &
		REQ_IS_READ & ~REQ_IS_WRITE & ~REQ_IS_ATOMIC & ENTRY_WRITE &
		~ENTRY_READ & ~ENTRY_RSVD_NZ & ~f_aw & ~f_win
		|=> RSP_VALID && !FAULT_VALID)
		else $error("zero-length read faulted");

	a_window_hit: assert property (
		take & legacy & ~root_bad & is_trd & ~over_host &
		(REQ_ADDR[63:`LDF_WIN_LO] == `LDF_WIN_BASE)
		|=> FAULT_REASON == `LDF_RSN_WIN && RSP_STATUS == ldf_pkg::LDF_UR)
		else $error("interrupt window fault missed");

	a_legacy_only: assert property (
		take & ~legacy & ~root_bad |=> RSP_VALID && !FAULT_VALID)
		else $error("fault outside legacy mode");

	a_mode_bad: assert property (
		take & (table_mode_field == `LDF_MODE_RSVD3) & is_tr
		|=> FAULT_REASON == `LDF_RSN_ROOT && !FAULT_QUALIFIED &&
			RSP_STATUS == ldf_pkg::LDF_CA)
		else $error("bad table mode not reported");

	a_pasid_legacy: assert property (
		take & legacy & ~root_bad & is_untr & REQ_HAS_PASID
		|=> FAULT_REASON == `LDF_RSN_PASID && RSP_STATUS == ldf_pkg::LDF_UR)
		else $error("pasid request not refused");

	a_fault_pairs: assert property (
		FAULT_VALID |-> RSP_VALID && RSP_STATUS != ldf_pkg::LDF_SUCCESS)
		else $error("fault without failing completion");

	c_untr_ur: cover property (
		take & is_untr ##1 RSP_STATUS == ldf_pkg::LDF_UR);
	c_tr_ca: cover property (
		take & is_tr ##1 RSP_STATUS == ldf_pkg::LDF_CA);
	c_tr_ok: cover property (
		take & is_tr & f_aw ##1 RSP_STATUS == ldf_pkg::LDF_SUCCESS);
	c_irq: cover property (IRQ ##1 !IRQ);

endmodule : ldf_fault_check

// ===== rtl/ldf_params.svh
// Constants for the legacy remap fault checker: offsets, fields, codes.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef LDF_PARAMS_SVH
`define LDF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LDF_OFF_ROOT 12'h000
`define LDF_OFF_CAP 12'h004
`define LDF_OFF_STAT 12'h008
`define LDF_OFF_MASK 12'h00C
`define LDF_OFF_LAST 12'h010

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define LDF_AW 12
`define LDF_DW 32
`define LDF_WW 7
`define LDF_MODE_LO 0
`define LDF_MODE_HI 1
`define LDF_MAX_GUEST_ADDR_WIDTH_LO 0
`define LDF_MAX_GUEST_ADDR_WIDTH_HI 6
`define LDF_HAW_LO 8
`define LDF_HAW_HI 14
`define LDF_ZLR_BIT 16
`define LDF_ST_QUAL 0
`define LDF_ST_NONQ 1
`define LDF_ST_W 2
`define LDF_LAST_RSN_HI 7
`define LDF_LAST_QUAL 8
`define LDF_LAST_ST_LO 9
`define LDF_LAST_ST_HI 11
`define LDF_WIN_LO 20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LDF_RST_MODE 2'h0
`define LDF_RST_MAX_GUEST_ADDR_WIDTH 7'h30
`define LDF_RST_HAW 7'h2E
`define LDF_RST_ZLR 1'h0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define LDF_MODE_LEGACY 2'h0
`define LDF_MODE_RSVD2 2'h2
`define LDF_MODE_RSVD3 2'h3
`define LDF_TT_PASS 2'h2
`define LDF_WIN_BASE 44'h00000000FEE
`define LDF_RSN_OVER 8'h04
`define LDF_RSN_WRITE 8'h05
`define LDF_RSN_READ 8'h06
`define LDF_RSN_RSVD 8'h0C
`define LDF_RSN_WIN 8'h0E
`define LDF_RSN_ROOT 8'h30
`define LDF_RSN_PASID 8'h31
`define LDF_RSN_PAGE 8'h32

`endif

// ===== rtl/ldf_pkg.sv
// Types shared by the fault checker and its bench.
// Assumes no other package; constants live in ldf_params.svh.
package ldf_pkg;

	// ------------------------------------------------------------------
	// Request kinds and completion outcomes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		LDF_UNTRANSLATED,
		LDF_TRANSLATION,
		LDF_TRANSLATED,
		LDF_PAGE_RESP,
		LDF_PAGE_NORESP
	} ldf_kind_t;

	typedef enum logic [2:0] {
		LDF_SUCCESS,
		LDF_UR,
		LDF_CA,
		LDF_IR,
		LDF_DROP
	} ldf_status_t;

endpackage : ldf_pkg

// ===== rtl/ldf_width_check.sv
// Address-width limit check: flags an address above 2^width - 1.
// Assumes a width of 0 to 64 bits; purely combinational.
`timescale 1ns/1ps
`include "ldf_params.svh"

module ldf_width_check (
	input wire logic [63:0] addr,
	input wire logic [`LDF_WW-1:0] width,
	output logic above
);

	// ------------------------------------------------------------------
	// Limit compare
	// ------------------------------------------------------------------
	function automatic logic above_limit(
		input logic [63:0] a,
		input logic [`LDF_WW-1:0] w
	);
		logic [63:0] keep;
		keep = '1;
		if (w < 7'h40) begin
			keep = ~({64{1'b1}} << w);
		end
		return (a & ~keep) != 64'h0;
	endfunction : above_limit

	assign above = above_limit(addr, width);

endmodule : ldf_width_check
